// [verilog/fbus_cfg.svh]
// Purpose: constants for the init sequencer and status indicators
// Assumes: 10 MHz clk, 32-bit AXI4-Lite register port
// Notes: Function list below
//
// Function
// R1: link indicator: steady link, flash activity, off
// R2: comm indicator steady when connected and running
// R3: comm indicator one flash when controller stopped
// R4: comm indicator off without controller connection
// R5: module indicator steady, diag flash, uninitialized off
// R6: identify request gives two green flashes
// R7: configuration error gives one red flash
// R8: three red for name/ip, four internal
// R9: generic mode adopts controller configuration itself
// R10: generic maps records, no diagnostics or alarms
// R11: generic plugs interface and port submodules automatically
// R12: advanced host plugs all modules and submodules
// R13: advanced routes records to host, mailbox diagnostics
// R14: advanced mode reads back actual controller configuration
// R15: generic order: start, bus init, options, end
// R16: advanced order: start, bus, mode, slot0, subslot1
// R17: slot 0 plugged before any other module
// R18: configured size within bus-init lengths, else error
// R19: record indexes 1000h/2000h map to parameter areas
// R20: reject plugs before slot 0 or outside init
`ifndef FBUS_CFG_SVH
`define FBUS_CFG_SVH
`define OFS_MSG      8'h00
`define OFS_BUSLEN   8'h04
`define OFS_MODSZ    8'h08
`define OFS_STAT     8'h0C
`define OFS_ACTCFG   8'h10
`define OFS_USED     8'h14
`define MSG_CODE_LSB 0
`define MSG_SLOT_LSB 8
`define MSG_SUB_LSB  16
`define MSG_FLAG_BIT 24
`define CODE_START   4'h1
`define CODE_BUSINIT 4'h2
`define CODE_ADVMODE 4'h3
`define CODE_SLOT    4'h4
`define CODE_SUBSLOT 4'h5
`define CODE_OTHER   4'h6
`define CODE_END     4'h7
`define RST_WORD     32'h0000_0000
`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10
`define REC_IN_BASE  16'h1000
`define REC_OUT_BASE 16'h2000
`define REC_MAP_TOP  16'h3000
`define REC_APP_TOP  16'h8000
`define CLK_HZ       10_000_000
`define FLASH_MS     200
`define GAP_UNITS    6
`define MAX_SLOTS    64
`endif

// [verilog/fbus_pkg.sv]
// Purpose: shared types for the init sequencer
// Assumes: constants live in fbus_cfg.svh
// Notes: structs carry bus, network and indicator groups
package fbus_pkg;
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axil_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;
  typedef struct packed {
    logic link;
    logic activity;
    logic connected;
    logic ctrl_run;
    logic diag_avail;
    logic ident_req;
    logic name_missing;
    logic ip_missing;
    logic internal_err;
    logic cfg_mismatch;
  } net_status_t;
  typedef struct packed {
    logic        valid;
    logic [6:0]  modules;
    logic [15:0] in_len;
    logic [15:0] out_len;
  } conn_cfg_t;
  typedef struct packed {
    logic link_green;
    logic comm_green;
    logic mod_green;
    logic mod_red;
  } led_t;
  typedef struct packed {
    logic       steady;
    logic [2:0] flashes;
  } led_mode_t;
  typedef enum logic [1:0] {rec_none, rec_param_in, rec_param_out, rec_host} rec_target_t;
  typedef enum logic [1:0] {st_idle, st_started, st_bus, st_run} init_state_t;
endpackage

// [verilog/led_flasher.sv]
// Purpose: steady / n-flash indicator pattern generator
// Assumes: mode held by caller, one unit per on or off phase
// Notes: pattern repeats after a dark gap
`timescale 1ns/100ps
`include "fbus_cfg.svh"
module led_flasher #(
  parameter int UNIT_CYC = 2_000_000
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire fbus_pkg::led_mode_t mode,
  output logic                   on
);
  import fbus_pkg::*;
  localparam int CW = $clog2(UNIT_CYC);
  localparam logic [4:0] GAP = 5'(`GAP_UNITS);
  if (UNIT_CYC < 2) begin : g_chk
    $error("led_flasher: UNIT_CYC must be at least 2");
  end
  logic [CW-1:0] cnt_r;
  logic [4:0]    slot_r;
  logic [4:0]    len;
  logic          unit_end;
  assign len      = {1'b0, mode.flashes, 1'b0};
  assign unit_end = (cnt_r == CW'(UNIT_CYC - 1));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= unit_end ? '0 : cnt_r + 1'b1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_r <= '0;
    end else if (unit_end) begin
      slot_r <= (slot_r >= len + GAP - 5'd1) ? 5'd0 : slot_r + 5'd1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      on <= 1'b0;
    end else begin
      on <= mode.steady | ((mode.flashes != 3'd0) & (slot_r < len) & ~slot_r[0]);
    end
  end
endmodule

// [verilog/record_router.sv]
// Purpose: steers a record index to parameter areas or the host
// Assumes: one request per rec_valid pulse
// Notes: result registered, valid one cycle later
`timescale 1ns/100ps
`include "fbus_cfg.svh"
module record_router (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  rec_valid,
  input  wire logic [15:0]           rec_index,
  input  wire logic                  map_param,
  output fbus_pkg::rec_target_t      target,
  output logic [11:0]                byte_ofs,
  output logic                       done
);
  import fbus_pkg::*;
  rec_target_t tgt_nxt;
  always_comb begin
    tgt_nxt = rec_none;
    if (rec_index < `REC_APP_TOP) begin
      if (!map_param) begin
        tgt_nxt = rec_host; // [R13]
      end else if (rec_index >= `REC_IN_BASE && rec_index < `REC_OUT_BASE) begin
        tgt_nxt = rec_param_in; // [R19]
      end else if (rec_index >= `REC_OUT_BASE && rec_index < `REC_MAP_TOP) begin
        tgt_nxt = rec_param_out; // [R19]
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      target   <= rec_none;
      byte_ofs <= '0;
      done     <= 1'b0;
    end else begin
      done <= rec_valid;
      if (rec_valid) begin
        target   <= tgt_nxt;
        byte_ofs <= rec_index[11:0];
      end
    end
  end
endmodule

// [verilog/init_sequencer.sv]
// Purpose: init message sequencer, mode selection and status indicators
// Assumes: network status and controller config come from same-clock logic
// Notes: mailbox messages are written to the message register
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "fbus_cfg.svh"
module init_sequencer #(
  parameter int FLASH_CYC = `FLASH_MS * (`CLK_HZ / 1000),
  parameter int MAX_SLOTS = `MAX_SLOTS
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire fbus_pkg::axil_req_t   axi_req,
  output fbus_pkg::axil_rsp_t        axi_rsp,
  input  wire fbus_pkg::net_status_t net,
  input  wire fbus_pkg::conn_cfg_t   conn,
  input  wire logic                  rec_valid,
  input  wire logic [15:0]           rec_index,
  output fbus_pkg::rec_target_t      rec_target,
  output logic [11:0]                rec_byte_ofs,
  output logic                       rec_done,
  output logic                       diag_enable,
  output logic                       io_ready,
  output fbus_pkg::led_t             leds
);
  import fbus_pkg::*;
  if (MAX_SLOTS < 1 || MAX_SLOTS > 127) begin : g_chk
    $error("init_sequencer: MAX_SLOTS must lie in 1..127");
  end
  localparam logic [6:0] SLOT_LIM = 7'(MAX_SLOTS);

  // bus slave channel state
  logic        aw_ok_r;
  logic        w_ok_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        wr_fire;
  logic        rd_fire;
  logic        wr_hit;

  // sequencer state
  init_state_t state_r;
  logic        adv_r;
  logic        rec_req_r;
  logic        slot0_r;
  logic        dap_sub_r;
  logic        ifport_r;
  logic        cfg_err_r;
  logic        resp_err_r;
  logic [3:0]  last_code_r;
  logic [7:0]  msg_cnt_r;
  logic [6:0]  mods_r;
  logic [31:0] buslen_r;
  logic [31:0] modsz_r;
  logic [15:0] in_lim_r;
  logic [15:0] out_lim_r;
  logic [16:0] used_in_r;
  logic [16:0] used_out_r;
  logic [15:0] act_in_r;
  logic [15:0] act_out_r;
  logic [6:0]  act_mods_r;

  // decoded message
  logic        msg_wr;
  logic [3:0]  code;
  logic [7:0]  slot;
  logic [7:0]  subslot;
  logic        msg_ok;
  logic [16:0] sum_in;
  logic [16:0] sum_out;
  logic        too_big;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // AXI4-Lite slave
  assign axi_rsp.awready = ~aw_ok_r & ~bvalid_r;
  assign axi_rsp.wready  = ~w_ok_r & ~bvalid_r;
  assign axi_rsp.bvalid  = bvalid_r;
  assign axi_rsp.bresp   = bresp_r;
  assign axi_rsp.arready = ~rvalid_r;
  assign axi_rsp.rvalid  = rvalid_r;
  assign axi_rsp.rdata   = rdata_r;
  assign axi_rsp.rresp   = rresp_r;
  assign wr_fire = aw_ok_r & w_ok_r & ~bvalid_r;
  assign rd_fire = axi_req.arvalid & ~rvalid_r;
  assign wr_hit  = (awaddr_r == `OFS_MSG) | (awaddr_r == `OFS_BUSLEN) |
                   (awaddr_r == `OFS_MODSZ);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_ok_r  <= 1'b0;
      awaddr_r <= '0;
    end else if (axi_req.awvalid & axi_rsp.awready) begin
      aw_ok_r  <= 1'b1;
      awaddr_r <= {axi_req.awaddr[7:2], 2'b00};
    end else if (wr_fire) begin
      aw_ok_r  <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_ok_r  <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (axi_req.wvalid & axi_rsp.wready) begin
      w_ok_r  <= 1'b1;
      wdata_r <= axi_req.wdata;
      wstrb_r <= axi_req.wstrb;
    end else if (wr_fire) begin
      w_ok_r  <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (axi_req.bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_r <= 1'b0;
      rdata_r  <= `RST_WORD;
      rresp_r  <= `RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rresp_r  <= `RESP_OKAY;
      case ({axi_req.araddr[7:2], 2'b00})
        `OFS_BUSLEN: rdata_r <= buslen_r;
        `OFS_MODSZ:  rdata_r <= modsz_r;
        `OFS_STAT:   rdata_r <= {2'b00, msg_cnt_r, 1'b0, mods_r, last_code_r, resp_err_r,
                                 cfg_err_r, ifport_r, dap_sub_r, slot0_r, rec_req_r,
                                 adv_r, 1'b0, 2'(state_r)};
        `OFS_ACTCFG: rdata_r <= adv_r ? {act_out_r, act_in_r} : `RST_WORD; // [R14]
        `OFS_USED:   rdata_r <= {used_out_r[15:0], used_in_r[15:0]};
        `OFS_MSG:    rdata_r <= `RST_WORD;
        default: begin
          rdata_r <= `RST_WORD;
          rresp_r <= `RESP_SLVERR;
        end
      endcase
    end else if (axi_req.rready) begin
      rvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buslen_r <= `RST_WORD;
      modsz_r  <= `RST_WORD;
    end else if (wr_fire && awaddr_r == `OFS_BUSLEN) begin
      buslen_r <= merge(buslen_r, wdata_r, wstrb_r);
    end else if (wr_fire && awaddr_r == `OFS_MODSZ) begin
      modsz_r  <= merge(modsz_r, wdata_r, wstrb_r);
    end
  end

  // message decode and acceptance
  assign msg_wr  = wr_fire & (awaddr_r == `OFS_MSG);
  assign code    = wdata_r[`MSG_CODE_LSB +: 4];
  assign slot    = wdata_r[`MSG_SLOT_LSB +: 8];
  assign subslot = wdata_r[`MSG_SUB_LSB +: 8];
  assign sum_in  = used_in_r + {1'b0, modsz_r[15:0]};
  assign sum_out = used_out_r + {1'b0, modsz_r[31:16]};
  assign too_big = (sum_in > {1'b0, in_lim_r}) | (sum_out > {1'b0, out_lim_r}); // [R18]

  always_comb begin
    msg_ok = 1'b0;
    case (code)
      `CODE_START:   msg_ok = (state_r == st_idle); // [R15] [R16]
      `CODE_BUSINIT: msg_ok = (state_r == st_started);
      `CODE_ADVMODE: msg_ok = (state_r == st_bus) & ~adv_r & ~slot0_r; // [R16]
      // plugs only inside the init window, advanced mode, slot 0 first
      `CODE_SLOT:    msg_ok = (state_r == st_bus) & adv_r & ~too_big & (mods_r < SLOT_LIM) &
                              ((slot == 8'h00) ? ~slot0_r : slot0_r); // [R17] [R20] [R12]
      `CODE_SUBSLOT: msg_ok = (state_r == st_bus) & adv_r & slot0_r &
                              ((slot != 8'h00) | (subslot != 8'h00)); // [R20] [R16]
      `CODE_OTHER:   msg_ok = (state_r == st_bus);
      `CODE_END:     msg_ok = (state_r == st_bus); // [R15]
      default:       msg_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= st_idle;
    end else if (msg_wr && msg_ok) begin
      case (code)
        `CODE_START:   state_r <= st_started;
        `CODE_BUSINIT: state_r <= st_bus;
        `CODE_END:     state_r <= st_run;
        default:       state_r <= state_r;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resp_err_r  <= 1'b0;
      last_code_r <= '0;
      msg_cnt_r   <= '0;
    end else if (msg_wr) begin
      resp_err_r  <= ~msg_ok; // [R20]
      last_code_r <= code;
      msg_cnt_r   <= msg_cnt_r + 8'd1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_lim_r  <= '0;
      out_lim_r <= '0;
      adv_r     <= 1'b0;
      rec_req_r <= 1'b0;
    end else if (msg_wr && msg_ok && code == `CODE_BUSINIT) begin
      in_lim_r  <= buslen_r[15:0];
      out_lim_r <= buslen_r[31:16];
    end else if (msg_wr && msg_ok && code == `CODE_ADVMODE) begin
      adv_r     <= 1'b1;
      rec_req_r <= wdata_r[`MSG_FLAG_BIT]; // [R13]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot0_r    <= 1'b0;
      dap_sub_r  <= 1'b0;
      mods_r     <= '0;
      used_in_r  <= '0;
      used_out_r <= '0;
    end else if (msg_wr && msg_ok && code == `CODE_SLOT) begin
      slot0_r    <= 1'b1; // [R17]
      mods_r     <= mods_r + 7'd1;
      used_in_r  <= sum_in;
      used_out_r <= sum_out;
    end else if (msg_wr && msg_ok && code == `CODE_SUBSLOT && slot == 8'h00) begin
      dap_sub_r  <= 1'b1; // [R16]
    end
  end

  // interface/port submodules plugged by the device itself in generic mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ifport_r <= 1'b0;
    end else if (msg_wr && msg_ok && code == `CODE_END) begin
      ifport_r <= ~adv_r | dap_sub_r; // [R11]
    end
  end

  // configuration from the controller connect service
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_in_r   <= '0;
      act_out_r  <= '0;
      act_mods_r <= '0;
    end else if (conn.valid && state_r == st_run) begin
      act_in_r   <= conn.in_len; // [R9] [R14]
      act_out_r  <= conn.out_len;
      act_mods_r <= conn.modules;
    end
  end

  // sticky configuration error, cleared by reset or by an accepted start message
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_err_r <= 1'b0;
    end else if (state_r == st_run && (net.cfg_mismatch ||
                 (conn.valid && (conn.in_len > in_lim_r || conn.out_len > out_lim_r ||
                                 conn.modules > SLOT_LIM)))) begin
      cfg_err_r <= 1'b1; // [R18] [R7]
    end else if (msg_wr && code == `CODE_SLOT && state_r == st_bus && adv_r &&
                 (too_big || mods_r >= SLOT_LIM)) begin
      cfg_err_r <= 1'b1; // [R18] [R7]
    end else if (msg_wr && msg_ok && code == `CODE_START) begin
      cfg_err_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      diag_enable <= 1'b0;
      io_ready    <= 1'b0;
    end else begin
      diag_enable <= adv_r & (state_r == st_run); // [R10] [R13]
      io_ready    <= (state_r == st_run) & ~cfg_err_r & (adv_r | (act_mods_r != 7'd0)); // [R9]
    end
  end

  record_router u_rec (
    .clk       (clk),
    .rst       (rst),
    .rec_valid (rec_valid),
    .rec_index (rec_index),
    .map_param (~adv_r | ~rec_req_r), // [R10] [R19]
    .target    (rec_target),
    .byte_ofs  (rec_byte_ofs),
    .done      (rec_done)
  );

  // indicator selection
  led_mode_t link_m;
  led_mode_t comm_m;
  led_mode_t mod_m;
  logic      mod_is_red;
  logic      link_on;
  logic      comm_on;
  logic      mod_on;

  always_comb begin
    link_m = '{steady: 1'b0, flashes: 3'd0};
    if (net.link) begin
      link_m = net.activity ? '{steady: 1'b0, flashes: 3'd1} :
                              '{steady: 1'b1, flashes: 3'd0}; // [R1]
    end
  end

  always_comb begin
    comm_m = '{steady: 1'b0, flashes: 3'd0}; // [R4]
    if (net.connected) begin
      comm_m = net.ctrl_run ? '{steady: 1'b1, flashes: 3'd0} : // [R2]
                              '{steady: 1'b0, flashes: 3'd1};  // [R3]
    end
  end

  always_comb begin
    mod_m      = '{steady: 1'b0, flashes: 3'd0};
    mod_is_red = 1'b0;
    if (net.internal_err) begin
      mod_m      = '{steady: 1'b0, flashes: 3'd4}; // [R8]
      mod_is_red = 1'b1;
    end else if (net.name_missing || net.ip_missing) begin
      mod_m      = '{steady: 1'b0, flashes: 3'd3}; // [R8]
      mod_is_red = 1'b1;
    end else if (cfg_err_r) begin
      mod_m      = '{steady: 1'b0, flashes: 3'd1}; // [R7]
      mod_is_red = 1'b1;
    end else if (net.ident_req) begin
      mod_m      = '{steady: 1'b0, flashes: 3'd2}; // [R6]
    end else if (state_r == st_run && adv_r && net.diag_avail) begin
      mod_m      = '{steady: 1'b0, flashes: 3'd1}; // [R5]
    end else if (state_r == st_run) begin
      mod_m      = '{steady: 1'b1, flashes: 3'd0}; // [R5]
    end
  end

  led_flasher #(.UNIT_CYC(FLASH_CYC)) u_link (
    .clk  (clk),
    .rst  (rst),
    .mode (link_m),
    .on   (link_on)
  );
  led_flasher #(.UNIT_CYC(FLASH_CYC)) u_comm (
    .clk  (clk),
    .rst  (rst),
    .mode (comm_m),
    .on   (comm_on)
  );
  led_flasher #(.UNIT_CYC(FLASH_CYC)) u_mod (
    .clk  (clk),
    .rst  (rst),
    .mode (mod_m),
    .on   (mod_on)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      leds <= '0;
    end else begin
      leds.link_green <= link_on;
      leds.comm_green <= comm_on;
      leds.mod_green  <= mod_on & ~mod_is_red;
      leds.mod_red    <= mod_on & mod_is_red;
    end
  end
endmodule

// [sim/init_seq_checker.sv]
// Purpose: port checks for init_sequencer
// Assumes: leds lag their causes by two cycles
// Notes: bound from the testbench top
`timescale 1ns/100ps
module init_seq_checker #(
  parameter int FLASH_CYC = 4,
  parameter int MAX_SLOTS = 64
) (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire fbus_pkg::axil_req_t   axi_req,
  input wire fbus_pkg::axil_rsp_t   axi_rsp,
  input wire fbus_pkg::net_status_t net,
  input wire logic                  rec_valid,
  input wire logic [15:0]           rec_index,
  input wire fbus_pkg::rec_target_t rec_target,
  input wire logic [11:0]           rec_byte_ofs,
  input wire logic                  rec_done,
  input wire fbus_pkg::led_t        leds
);
  import fbus_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ar_take;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  sequence s_b_wait;
    axi_rsp.bvalid && !axi_req.bready;
  endsequence
  a_read_answer: assert property (s_ar_take |=> axi_rsp.rvalid)
    else $error("read not answered next cycle");
  a_bresp_hold: assert property (s_b_wait |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped early");
  a_rec_done: assert property (rec_valid |=> rec_done)
    else $error("record routing not done");
  a_rec_ofs: assert property (rec_valid |=> rec_byte_ofs == $past(rec_index[11:0]))
    else $error("record byte offset wrong");
  a_rec_high: assert property (rec_valid && rec_index[15] |=> rec_target == rec_none)
    else $error("high record index mapped");
  a_link_off: assert property ((!net.link)[*4] |-> !leds.link_green)
    else $error("link led lit without link");
  a_link_on: assert property ((net.link && !net.activity)[*4] |-> leds.link_green)
    else $error("link led not steady");
  a_comm_off: assert property ((!net.connected)[*4] |-> !leds.comm_green)
    else $error("comm led lit offline");
  a_comm_run: assert property ((net.connected && net.ctrl_run)[*4] |-> leds.comm_green)
    else $error("comm led not steady in run");
  a_red_err: assert property (net.internal_err[*4] |-> !leds.mod_green)
    else $error("green module led on internal error");
endmodule

// [sim/host_axi.sv]
// Purpose: host processor model on the register port
// Assumes: one transfer at a time
// Notes: waits for the answer without a cycle count
`timescale 1ns/100ps
module host_axi (
  input  wire logic                clk,
  input  wire fbus_pkg::axil_rsp_t axi_rsp,
  output fbus_pkg::axil_req_t      axi_req
);
  import fbus_pkg::*;
  initial axi_req = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_t, w_t, b_t;
    @(posedge clk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr  <= a;
    axi_req.wvalid  <= 1'b1;
    axi_req.wdata   <= d;
    axi_req.wstrb   <= 4'hf;
    do begin
      @(negedge clk);
      aw_t = axi_req.awvalid && axi_rsp.awready;
      w_t  = axi_req.wvalid && axi_rsp.wready;
      b_t  = axi_rsp.bvalid;
      r    = axi_rsp.bresp;
      @(posedge clk);
      if (aw_t) axi_req.awvalid <= 1'b0;
      if (w_t) axi_req.wvalid <= 1'b0;
      axi_req.bready <= b_t & ~axi_req.bready;
    end while (!(b_t && axi_req.bready));
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic a_t, r_t;
    @(posedge clk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr  <= a;
    axi_req.rready  <= 1'b1;
    do begin
      @(negedge clk);
      a_t = axi_req.arvalid && axi_rsp.arready;
      r_t = axi_rsp.rvalid;
      d   = axi_rsp.rdata;
      r   = axi_rsp.rresp;
      @(posedge clk);
      if (a_t) axi_req.arvalid <= 1'b0;
    end while (!r_t);
    axi_req.rready <= 1'b0;
  endtask
endmodule

// [sim/fieldbus_init_sequencer_status_leds_tb.sv]
// Purpose: self-checking bench for init_sequencer
// Assumes: short flash unit for quick led patterns
// Notes: generic run, then advanced run after a second reset
`timescale 1ns/100ps
`include "fbus_cfg.svh"
module fieldbus_init_sequencer_status_leds_tb;
  import fbus_pkg::*;
  localparam int FC = 4;
  logic        clk, rst, rec_valid, rec_done, diag_enable, io_ready;
  logic [15:0] rec_index;
  logic [11:0] rec_byte_ofs;
  logic [3:0]  ledv;
  logic [31:0] rdat;
  logic [1:0]  resp;
  axil_req_t   axi_req;
  axil_rsp_t   axi_rsp;
  net_status_t net;
  conn_cfg_t   conn;
  rec_target_t rec_target;
  led_t        leds;
  int          bad_count = 0;
  int          checks = 0;
  int          cyc = 0;
  assign ledv = leds;
  init_sequencer #(.FLASH_CYC(FC), .MAX_SLOTS(64)) dut_u (.clk(clk), .rst(rst),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .net(net), .conn(conn), .rec_valid(rec_valid),
    .rec_index(rec_index), .rec_target(rec_target), .rec_byte_ofs(rec_byte_ofs),
    .rec_done(rec_done), .diag_enable(diag_enable), .io_ready(io_ready), .leds(leds));
  host_axi host_u (.clk(clk), .axi_rsp(axi_rsp), .axi_req(axi_req));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // message write, rejection flag read back
  task automatic msg(input logic [3:0] c, input logic [7:0] s, input logic [7:0] ss,
                     input logic e);
    host_u.wr(`OFS_MSG, {7'h00, c == 4'h3, ss, s, 4'h0, c}, resp);
    host_u.rd(`OFS_STAT, rdat, resp);
    chk(32'(rdat[9]), 32'(e));
  endtask
  // settle two periods, count flashes in one
  task automatic nf(input logic [9:0] v, input int sel, input int n, input logic lvl);
    int  p, k;
    logic prev;
    @(posedge clk);
    net <= v;
    p = (n == 0) ? 8 * FC : (2 * n + 6) * FC;
    repeat (2 * p) @(posedge clk);
    k = 0;
    prev = ledv[sel];
    repeat (p) begin
      @(negedge clk);
      if (ledv[sel] && !prev) k++;
      prev = ledv[sel];
    end
    chk(32'(k), 32'(n));
    if (n == 0) chk(32'(ledv[sel]), 32'(lvl));
  endtask
  task automatic rec(input logic [15:0] i, input rec_target_t t);
    @(posedge clk);
    rec_valid <= 1'b1;
    rec_index <= i;
    @(posedge clk);
    rec_valid <= 1'b0;
    @(negedge clk);
    chk(32'(rec_target), 32'(t));
  endtask
  task automatic cn(input logic [6:0] m, input logic [15:0] il, input logic [15:0] ol);
    @(posedge clk);
    conn <= {1'b1, m, il, ol};
    @(posedge clk);
    conn.valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_generic();
    host_u.rd(`OFS_STAT, rdat, resp);
    chk(rdat, 32'h0000_0000);
    host_u.rd(8'h20, rdat, resp);
    chk({rdat[29:0], resp}, 32'h0000_0002);
    host_u.wr(`OFS_STAT, 32'h0000_0001, resp);
    chk(32'(resp), 32'h0000_0002);
    host_u.wr(`OFS_BUSLEN, 32'h0040_0040, resp);
    host_u.rd(`OFS_BUSLEN, rdat, resp);
    chk(rdat, 32'h0040_0040);
    msg(`CODE_SLOT, 8'h00, 8'h00, 1'b1);
    msg(`CODE_START, 8'h00, 8'h00, 1'b0);
    msg(`CODE_BUSINIT, 8'h00, 8'h00, 1'b0);
    msg(`CODE_SLOT, 8'h00, 8'h00, 1'b1);
    msg(`CODE_OTHER, 8'h00, 8'h00, 1'b0);
    msg(`CODE_END, 8'h00, 8'h00, 1'b0);
    chk(32'(rdat[9:0]), 32'h0000_0083);
    msg(`CODE_SLOT, 8'h00, 8'h00, 1'b1);
    rec(16'h1000, rec_param_in);
    chk(32'(rec_done), 32'h0000_0001);
    rec(16'h2fff, rec_param_out);
    rec(16'h8000, rec_none);
    cn(7'h03, 16'h0020, 16'h0020);
    chk(32'(io_ready), 32'h0000_0001);
    nf(10'h000, 3, 0, 1'b0);
    nf(10'h200, 3, 0, 1'b1);
    nf(10'h300, 3, 1, 1'b0);
    nf(10'h0c0, 2, 0, 1'b1);
    nf(10'h080, 2, 1, 1'b0);
    nf(10'h000, 2, 0, 1'b0);
    nf(10'h000, 1, 0, 1'b1);
    nf(10'h020, 1, 0, 1'b1);
  endtask
  task automatic t_adv();
    @(posedge clk);
    rst <= 1'b1;
    net <= '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    host_u.wr(`OFS_BUSLEN, 32'h0040_0040, resp);
    host_u.wr(`OFS_MODSZ, 32'h0010_0010, resp);
    msg(`CODE_START, 8'h00, 8'h00, 1'b0);
    msg(`CODE_BUSINIT, 8'h00, 8'h00, 1'b0);
    msg(`CODE_ADVMODE, 8'h00, 8'h00, 1'b0);
    msg(`CODE_SLOT, 8'h01, 8'h00, 1'b1);
    msg(`CODE_SLOT, 8'h00, 8'h00, 1'b0);
    msg(`CODE_SUBSLOT, 8'h00, 8'h01, 1'b0);
    msg(`CODE_SLOT, 8'h01, 8'h00, 1'b0);
    msg(`CODE_END, 8'h00, 8'h00, 1'b0);
    chk(32'(rdat[8:0] & 9'h17f), 32'h0000_007b);
    chk(32'(diag_enable), 32'h0000_0001);
    rec(16'h2000, rec_host);
    cn(7'h02, 16'h0030, 16'h0028);
    host_u.rd(`OFS_ACTCFG, rdat, resp);
    chk(rdat, 32'h0028_0030);
    nf(10'h020, 1, 1, 1'b0);
    nf(10'h010, 1, 2, 1'b0);
    cn(7'h02, 16'h0100, 16'h0010);
    host_u.rd(`OFS_STAT, rdat, resp);
    chk(32'(rdat[8]), 32'h0000_0001);
    nf(10'h000, 0, 1, 1'b0);
    nf(10'h008, 0, 3, 1'b0);
    nf(10'h002, 0, 4, 1'b0);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    rst = 1'b1;
    net = '0;
    conn = '0;
    rec_valid = 1'b0;
    rec_index = 16'h0000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_generic();
    t_adv();
    stop_test();
  end
endmodule
bind init_sequencer init_seq_checker #(.FLASH_CYC(FLASH_CYC), .MAX_SLOTS(MAX_SLOTS)) chk_u (
  .clk(clk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp), .net(net),
  .rec_valid(rec_valid), .rec_index(rec_index), .rec_target(rec_target),
  .rec_byte_ofs(rec_byte_ofs), .rec_done(rec_done), .leds(leds));
